// ### core/ptsq_top.v
// Pattern trigger sequencer with AXI4-Lite registers and setup store
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ptsq_map.vh"
module ptsq_top
#(
	parameter ADDR_W = 8,
	parameter PAT_WORDS = 512
)
(
	input wire clk_in,
	input wire rst_in,
	input wire [ADDR_W-1:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [ADDR_W-1:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire external_trigger_input_in,
	input wire external_clock_input_in,
	input wire internal_oscillator_in,
	input wire pll_tick_in,
	output reg pattern_out,
	output reg period_strobe_out,
	output reg channel_enabled_out,
	output reg busy_out
);

	//----------------------------------------------------------------------
	// Storage
	//----------------------------------------------------------------------
	reg [7:0] ctrl_q;
	reg [14:0] len_q;
	reg [15:0] burst_q;
	reg [8:0] paddr_q;
	reg [31:0] pat_mem [0:PAT_WORDS-1];
	reg [7:0] slot_ctrl [0:8];
	reg [14:0] slot_len [0:8];
	reg [15:0] slot_burst [0:8];
	reg en_q;
	reg run_q;
	reg stop_q;
	reg [15:0] idx_q;

	//----------------------------------------------------------------------
	// Pin synchronisers
	//----------------------------------------------------------------------
	reg [2:0] trg_sync_q;
	reg [2:0] clk_sync_q;

	// Two flops per pin, third flop only for edge detection
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			trg_sync_q <= 3'h0;
			clk_sync_q <= 3'h0;
		end
		else
		begin
			trg_sync_q <= {trg_sync_q[1:0], external_trigger_input_in};
			clk_sync_q <= {clk_sync_q[1:0], external_clock_input_in};
		end
	end

	wire trg_rise = trg_sync_q[1] & ~trg_sync_q[2];
	wire trg_fall = ~trg_sync_q[1] & trg_sync_q[2];
	wire clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
	wire clk_fall = ~clk_sync_q[1] & clk_sync_q[2];

	//----------------------------------------------------------------------
	// AXI4-Lite write path
	//----------------------------------------------------------------------
	reg aw_got_q;
	reg w_got_q;
	reg [ADDR_W-1:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire wr_go = aw_got_q & w_got_q & ~s_axi_bvalid_out;
	wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [7:0] wa = waddr_q[7:0];
	wire wr_known = (wa == `PTSQ_OFF_CTRL) | (wa == `PTSQ_OFF_CMD) | (wa == `PTSQ_OFF_LEN) |
		(wa == `PTSQ_OFF_BURST) | (wa == `PTSQ_OFF_PADDR) | (wa == `PTSQ_OFF_PDATA) |
		(wa == `PTSQ_OFF_STAT);

	// Address and data are taken in either order, one write at a time
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= {ADDR_W{1'b0}};
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `PTSQ_RESP_OKAY;
		end
		else
		begin
			s_axi_awready_out <= ~aw_got_q & ~s_axi_awready_out & s_axi_awvalid_in;
			s_axi_wready_out <= ~w_got_q & ~s_axi_wready_out & s_axi_wvalid_in;
			if (s_axi_awvalid_in & s_axi_awready_out)
			begin
				aw_got_q <= 1'b1;
				waddr_q <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in & s_axi_wready_out)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
			end
			if (wr_go)
			begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_known ? `PTSQ_RESP_OKAY : `PTSQ_RESP_SLVERR;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	//----------------------------------------------------------------------
	// Commands decoded from the write
	//----------------------------------------------------------------------
	wire cmd_wr = wr_go & (wa == `PTSQ_OFF_CMD) & wstrb_q[0] & wstrb_q[1];
	wire [3:0] slot_num = wdata_q[`PTSQ_CMD_SLOT];
	wire slot_ok = (slot_num != 4'h0) & (slot_num <= `PTSQ_SLOTS);
	wire [3:0] slot_ix = slot_num - 4'h1;
	wire cmd_toggle = cmd_wr & wdata_q[`PTSQ_CMD_ENABLE];
	wire cmd_manual = cmd_wr & wdata_q[`PTSQ_CMD_MANUAL];
	wire cmd_save = cmd_wr & wdata_q[`PTSQ_CMD_SAVE] & slot_ok;
	wire cmd_recall = cmd_wr & wdata_q[`PTSQ_CMD_RECALL] & slot_ok;
	wire cmd_default = cmd_wr & wdata_q[`PTSQ_CMD_DEFAULT];
	wire [31:0] ctrl_m = ({24'h0, ctrl_q} & ~wmask) | (wdata_q & wmask);
	wire [31:0] len_m = ({17'h0, len_q} & ~wmask) | (wdata_q & wmask);
	wire [31:0] burst_m = ({16'h0, burst_q} & ~wmask) | (wdata_q & wmask);

	// Length is clamped into the legal pattern range
	wire [14:0] len_new = (len_m[31:15] != 17'h0) ? `PTSQ_LEN_MAX :
		(len_m[14:0] > `PTSQ_LEN_MAX) ? `PTSQ_LEN_MAX :
		(len_m[14:0] < `PTSQ_LEN_MIN) ? `PTSQ_LEN_MIN : len_m[14:0];
	// Burst register holds count minus one, so a count below two is lifted to two
	wire [15:0] burst_new = (burst_m[15:0] < `PTSQ_BURST_M1_MIN) ? `PTSQ_BURST_M1_MIN :
		burst_m[15:0];

	// Settings registers; a recall or default load overrides a plain write
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl_q <= `PTSQ_CTRL_RST;
			len_q <= `PTSQ_LEN_RST;
			burst_q <= `PTSQ_BURST_M1_RST;
			paddr_q <= 9'h000;
		end
		else if (cmd_default)
		begin
			ctrl_q <= `PTSQ_CTRL_RST;
			len_q <= `PTSQ_LEN_RST;
			burst_q <= `PTSQ_BURST_M1_RST;
		end
		else if (cmd_recall)
		begin
			ctrl_q <= slot_ctrl[slot_ix];
			len_q <= slot_len[slot_ix];
			burst_q <= slot_burst[slot_ix];
		end
		else if (wr_go)
		begin
			if (wa == `PTSQ_OFF_CTRL)
				ctrl_q <= ctrl_m[7:0];
			if (wa == `PTSQ_OFF_LEN)
				len_q <= len_new;
			if (wa == `PTSQ_OFF_BURST)
				burst_q <= burst_new;
			if (wa == `PTSQ_OFF_PADDR)
				paddr_q <= wdata_q[8:0];
			if (wa == `PTSQ_OFF_PDATA)
				paddr_q <= paddr_q + 9'h001;
		end
	end

	// Pattern words and setup slots; memories carry no reset
	always @(posedge clk_in)
	begin
		if (wr_go & (wa == `PTSQ_OFF_PDATA))
			pat_mem[paddr_q] <= (pat_mem[paddr_q] & ~wmask) | (wdata_q & wmask);
		if (cmd_save)
		begin
			slot_ctrl[slot_ix] <= ctrl_q;
			slot_len[slot_ix] <= len_q;
			slot_burst[slot_ix] <= burst_q;
		end
	end

	//----------------------------------------------------------------------
	// AXI4-Lite read path
	//----------------------------------------------------------------------
	reg [31:0] rd_mux;
	reg rd_known;

	always @*
	begin
		rd_known = 1'b1;
		case (s_axi_araddr_in[7:0])
			`PTSQ_OFF_CTRL: rd_mux = {24'h0, ctrl_q};
			`PTSQ_OFF_CMD: rd_mux = 32'h0;
			`PTSQ_OFF_LEN: rd_mux = {17'h0, len_q};
			`PTSQ_OFF_BURST: rd_mux = {16'h0, burst_q};
			`PTSQ_OFF_PADDR: rd_mux = {23'h0, paddr_q};
			`PTSQ_OFF_PDATA: rd_mux = pat_mem[paddr_q];
			`PTSQ_OFF_STAT: rd_mux = {idx_q, 13'h0, stop_q, run_q, en_q};
			default:
			begin
				rd_mux = 32'h0;
				rd_known = 1'b0;
			end
		endcase
	end

	// Address taken one cycle after valid, data the cycle after that
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= `PTSQ_RESP_OKAY;
		end
		else
		begin
			s_axi_arready_out <= s_axi_arvalid_in & ~s_axi_arready_out & ~s_axi_rvalid_out;
			if (s_axi_arvalid_in & s_axi_arready_out)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_mux;
				s_axi_rresp_out <= rd_known ? `PTSQ_RESP_OKAY : `PTSQ_RESP_SLVERR;
			end
			else if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	//----------------------------------------------------------------------
	// Trigger and period selection
	//----------------------------------------------------------------------
	wire [1:0] mode = ctrl_q[`PTSQ_CTRL_MODE];
	wire [1:0] src = ctrl_q[`PTSQ_CTRL_SRC];
	wire [1:0] per = ctrl_q[`PTSQ_CTRL_PER];
	wire burst_mode = ctrl_q[`PTSQ_CTRL_BURST];
	wire pll_launch = (mode == `PTSQ_MODE_TRIG) & (src == `PTSQ_SRC_PLL);
	wire ext_edge = ctrl_q[`PTSQ_CTRL_NEG] ? clk_fall : clk_rise;
	// the PLL launches passes, so bits are timed by the oscillator
	wire tick = (pll_launch | (per == `PTSQ_PER_OSC)) ? internal_oscillator_in :
		(per == `PTSQ_PER_PLL) ? pll_tick_in : ((per == `PTSQ_PER_EXTCLK) & ext_edge);

	// triggered launch from edge, PLL or command
	wire trig_start = (src == `PTSQ_SRC_EXT) ? trg_rise :
		(src == `PTSQ_SRC_PLL) ? pll_tick_in : ((src == `PTSQ_SRC_MANUAL) & cmd_manual);
	// idle launch: continuous at once, gate on its leading edge
	wire start = (mode == `PTSQ_MODE_CONT) | ((mode == `PTSQ_MODE_TRIG) & trig_start) |
		((mode == `PTSQ_MODE_GATED) & trg_rise);

	//----------------------------------------------------------------------
	// Pass sequencer
	//----------------------------------------------------------------------
	wire [15:0] len_m1 = {1'b0, len_q} - 16'h0001;
	// burst runs count periods instead of the pattern length
	wire last = (idx_q >= (burst_mode ? burst_q : len_m1)); // A length cut mid-pass still ends it
	wire cur_bit = burst_mode ? 1'b1 : pat_mem[idx_q[13:5]][idx_q[4:0]];
	// loop in continuous mode; gated passes loop until a trailing edge
	wire again = (mode == `PTSQ_MODE_CONT) | ((mode == `PTSQ_MODE_GATED) & ~stop_q);
	// a load beats a toggle arriving with it
	wire en_d = (cmd_recall | cmd_default) ? 1'b0 : (cmd_toggle ? ~en_q : en_q);

	// Enable state and pass progress
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			en_q <= 1'b0;
			run_q <= 1'b0;
			stop_q <= 1'b0;
			idx_q <= 16'h0000;
		end
		else
		begin
			en_q <= en_d;
			if (~en_d)
			begin
				run_q <= 1'b0;
				stop_q <= 1'b0;
				idx_q <= 16'h0000;
			end
			// enabled channel waits for its trigger
			else if (~run_q)
			begin
				run_q <= en_q & start;
				stop_q <= 1'b0;
				idx_q <= 16'h0000;
			end
			else
			begin
				// trailing edge only marks the pass, it does not cut it
				if ((mode == `PTSQ_MODE_GATED) & trg_fall)
					stop_q <= 1'b1;
				if (tick & last)
				begin
					idx_q <= 16'h0000;
					run_q <= again & ~((mode == `PTSQ_MODE_GATED) & trg_fall);
				end
				else if (tick)
					idx_q <= idx_q + 16'h0001;
			end
		end
	end

	// Output stage; every output leaves straight from a flop
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pattern_out <= 1'b0;
			period_strobe_out <= 1'b0;
			channel_enabled_out <= 1'b0;
			busy_out <= 1'b0;
		end
		else
		begin
			period_strobe_out <= run_q & en_d & tick;
			if (~(run_q & en_d))
				pattern_out <= 1'b0;
			else if (tick)
				pattern_out <= cur_bit;
			channel_enabled_out <= en_d;
			busy_out <= run_q & en_d;
		end
	end

endmodule // ptsq_top

// ### core/ptsq_map.vh
// Register map, field layout and constants of the pattern trigger sequencer
//--------------------------------------------------------------------------
// What this block does
// - Continuous mode starts output at once, ignores the trigger and loops the pattern while enabled.
// - Triggered mode on the external input emits exactly one full pass per active edge, then waits.
// - Triggered mode on the PLL source lets the PLL start each pass while the oscillator times bits.
// - Triggered mode on manual source emits one pass per manual trigger command, then stays idle.
// - Gated mode starts at the gate leading edge and the trailing edge marks the final pass.
// - No output until the channel is enabled, and then only as the trigger setup dictates.
// - An enable command on an enabled channel disables it and clears its enabled status.
// - Nine setup slots can each be saved and recalled, a recall restoring every saved setting.
// - The power-on default setup can be loaded at any time.
// - Loading a slot or the default setup forces the channel output disabled.
// - In burst operation each trigger emits a programmed count of 2 to 65536 periods.
// - On the external clock each detected edge advances one period, with selectable polarity.
//--------------------------------------------------------------------------
`ifndef PTSQ_MAP_VH
`define PTSQ_MAP_VH
// Register byte offsets
`define PTSQ_OFF_CTRL 8'h00
`define PTSQ_OFF_CMD 8'h04
`define PTSQ_OFF_LEN 8'h08
`define PTSQ_OFF_BURST 8'h0c
`define PTSQ_OFF_PADDR 8'h10
`define PTSQ_OFF_PDATA 8'h14
`define PTSQ_OFF_STAT 8'h18
// Control register fields
`define PTSQ_CTRL_MODE 1:0
`define PTSQ_CTRL_SRC 3:2
`define PTSQ_CTRL_PER 5:4
`define PTSQ_CTRL_NEG 6
`define PTSQ_CTRL_BURST 7
`define PTSQ_CTRL_RST 8'h00
// Command register fields, each bit a one-shot
`define PTSQ_CMD_ENABLE 0
`define PTSQ_CMD_MANUAL 1
`define PTSQ_CMD_SAVE 2
`define PTSQ_CMD_RECALL 3
`define PTSQ_CMD_DEFAULT 4
`define PTSQ_CMD_SLOT 11:8
// Trigger modes, trigger sources, period sources
`define PTSQ_MODE_CONT 2'h0
`define PTSQ_MODE_TRIG 2'h1
`define PTSQ_MODE_GATED 2'h2
`define PTSQ_SRC_EXT 2'h0
`define PTSQ_SRC_PLL 2'h1
`define PTSQ_SRC_MANUAL 2'h2
`define PTSQ_PER_OSC 2'h0
`define PTSQ_PER_PLL 2'h1
`define PTSQ_PER_EXTCLK 2'h2
// Length and burst limits, resets
`define PTSQ_LEN_MIN 15'h0002
`define PTSQ_LEN_MAX 15'h4000
`define PTSQ_LEN_RST 15'h0010
`define PTSQ_BURST_M1_MIN 16'h0001
`define PTSQ_BURST_M1_RST 16'h0001
`define PTSQ_SLOTS 4'h9
// Bus answers
`define PTSQ_RESP_OKAY 2'h0
`define PTSQ_RESP_SLVERR 2'h2
`endif

// ### test/ptsq_assertions.sv
// Port-level assertions for the pattern trigger sequencer
`timescale 1ns/1ps
module ptsq_assertions
(
	input wire clk_in,
	input wire rst_in,
	input wire s_axi_awvalid_in,
	input wire s_axi_awready_out,
	input wire s_axi_wvalid_in,
	input wire s_axi_wready_out,
	input wire s_axi_bvalid_out,
	input wire s_axi_arvalid_in,
	input wire s_axi_arready_out,
	input wire s_axi_rvalid_out,
	input wire pattern_out,
	input wire period_strobe_out,
	input wire channel_enabled_out,
	input wire busy_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Both write channels taken at one edge
	sequence wr_take;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// Answer stands one beat since the bench holds its ready high
	sequence one_beat(sig);
		sig ##1 !sig;
	endsequence
	aw_pulse_a: assert property (s_axi_awready_out |=> !s_axi_awready_out)
		else $error("awready longer than one cycle");
	w_pulse_a: assert property (s_axi_wready_out |=> !s_axi_wready_out)
		else $error("wready longer than one cycle");
	ar_pulse_a: assert property (s_axi_arready_out |=> !s_axi_arready_out)
		else $error("arready longer than one cycle");
	wr_answer_a: assert property (wr_take |=> ##1 one_beat(s_axi_bvalid_out))
		else $error("write answer late or stuck");
	rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> one_beat(s_axi_rvalid_out))
		else $error("read answer late or stuck");
	strobe_busy_a: assert property (period_strobe_out |-> busy_out)
		else $error("period strobe outside a run");
	idle_low_a: assert property (!busy_out |-> !pattern_out)
		else $error("pattern bit while idle");
	en_cause_a: assert property ($changed(channel_enabled_out)
		|-> s_axi_bvalid_out || $past(s_axi_bvalid_out))
		else $error("enable changed without a command");
endmodule // ptsq_assertions
bind ptsq_top ptsq_assertions ptsq_assertions_inst
(
	.clk_in(clk_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
	.s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .pattern_out(pattern_out),
	.period_strobe_out(period_strobe_out), .channel_enabled_out(channel_enabled_out),
	.busy_out(busy_out)
);

// ### test/ptsq_partner.sv
// Far-side model: trigger pin, external clock, oscillator and PLL ticks
`timescale 1ns/1ps
module ptsq_partner
(
	input wire clk_in,
	output reg ext_trig_out,
	output reg ext_clk_out,
	output reg osc_tick_out,
	output reg pll_tick_out
);
	integer cnt;
	initial
	begin
		cnt = 0;
		ext_trig_out = 1'b0;
		ext_clk_out = 1'b0;
		osc_tick_out = 1'b0;
		pll_tick_out = 1'b0;
	end
	// tick sources
	// Slow PLL rate keeps oscillator-timed passes apart
	always @(posedge clk_in)
	begin
		cnt <= cnt + 1;
		osc_tick_out <= cnt % 3 == 0;
		pll_tick_out <= cnt % 97 == 5;
	end
	// free-running clock
	// Odd half period, so edges drift against the system clock
	always #37 ext_clk_out = ~ext_clk_out;
	task pulse(input integer hi);
	begin
		@(posedge clk_in);
		ext_trig_out <= 1'b1;
		repeat (hi) @(posedge clk_in);
		ext_trig_out <= 1'b0;
	end
	endtask
endmodule // ptsq_partner

// ### test/tb_top.sv
// Self-checking bench for the pattern trigger sequencer
`timescale 1ns/1ps
module tb_top;
	reg clk_in, rst_in, awv, wv, bry, arv, rry;
	reg [7:0] awa, ara;
	reg [31:0] wd, rd_v, pw, got;
	reg [1:0] rr;
	reg [15:0] lf;
	wire awr, wr_r, bv, arr, rv, trig, eclk, osc, pll, pat, stb, en, busy;
	wire [1:0] br, rrs;
	wire [31:0] rdat;
	integer bad_count, checks_done, nstb, cyc, i, j;
	integer pat_q[$];
	ptsq_top ptsq_top_inst
	(
		.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(br),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
		.s_axi_rresp_out(rrs), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
		.external_trigger_input_in(trig), .external_clock_input_in(eclk),
		.internal_oscillator_in(osc), .pll_tick_in(pll), .pattern_out(pat),
		.period_strobe_out(stb), .channel_enabled_out(en), .busy_out(busy)
	);
	ptsq_partner ptsq_partner_inst
	(
		.clk_in(clk_in), .ext_trig_out(trig), .ext_clk_out(eclk), .osc_tick_out(osc),
		.pll_tick_out(pll)
	);
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Reference model: bits expected from n periods over a pattern of len bits
	function [31:0] model_bits(input integer n, input integer len, input integer burst);
		integer k;
		begin
			model_bits = 32'h0;
			for (k = 0; k < n && k < 32; k = k + 1)
				model_bits[k] = (burst != 0) || (pat_q[k % len] != 0);
		end
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// Write: both channels offered, each dropped once taken
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge clk_in);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do
		begin
			@(posedge clk_in);
			if (awr === 1'b1)
				awv <= 1'b0;
			if (wr_r === 1'b1)
				wv <= 1'b0;
		end
		while (bv !== 1'b1);
		rr = br;
		bry <= 1'b0;
	end
	endtask
	task rd(input [7:0] a);
	begin
		@(posedge clk_in);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do
		begin
			@(posedge clk_in);
			if (arr === 1'b1)
				arv <= 1'b0;
		end
		while (rv !== 1'b1);
		rd_v = rdat;
		rr = rrs;
		rry <= 1'b0;
	end
	endtask
	// Command, then let the enable status settle
	task cmd(input [31:0] d);
	begin
		wr(8'h04, d);
		repeat (2) @(posedge clk_in);
		#1;
	end
	endtask
	// One run: strobe count, bits in order, length in cycles
	task pass(input integer n, input [31:0] e);
	begin
		cyc = 0;
		for (i = 0; i < 300 && busy !== 1'b1; i = i + 1)
			@(posedge clk_in);
		while (busy === 1'b1)
		begin
			@(posedge clk_in);
			cyc = cyc + 1;
		end
		@(posedge clk_in);
		chk(nstb, n);
		chk(got, e);
		nstb = 0;
		got = 0;
	end
	endtask
	// Bits are collected at each of the first 32 period strobes
	always @(posedge clk_in)
		if (stb === 1'b1 && nstb < 32)
		begin
			got[nstb] = pat;
			nstb = nstb + 1;
		end
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Hang guard, well past the expected run length
	initial
	begin
		#500000;
		bad_count = bad_count + 1;
		report_and_stop;
	end
	initial
	begin
		{awv, wv, bry, arv, rry, awa, ara, wd, got} = 0;
		bad_count = 0;
		checks_done = 0;
		nstb = 0;
		rst_in = 1'b1;
		lf = 16'h0010;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(8'h00);
		chk(rd_v, 0);
		chk(rr, 0);
		rd(8'h08);
		chk(rd_v, 16);
		rd(8'h0c);
		chk(rd_v, 1);
		rd(8'h1c);
		chk(rr, 2);
		wr(8'h1c, 0);
		chk(rr, 2);
		lf = lfsr(lfsr(lf));
		pw = {lf, lfsr(lf)};
		wr(8'h10, 0);
		wr(8'h14, pw);
		for (i = 0; i < 32; i = i + 1)
			pat_q.push_back(pw[i]);
		wr(8'h08, 8);
		chk(rr, 0);
		wr(8'h00, 8'h09);
		cmd(2);
		pass(0, 0);
		cmd(1);
		chk(en, 1);
		rd(8'h18);
		chk(rd_v[0], 1);
		// Manual pass on each period source, then negative slope
		for (j = 0; j < 4; j = j + 1)
		begin
			wr(8'h00, {1'b0, j == 3, j == 3 ? 2'h2 : j[1:0], 4'h9});
			cmd(2);
			pass(8, model_bits(8, 8, 0));
		end
		wr(8'h00, 1);
		ptsq_partner_inst.pulse(2);
		pass(8, model_bits(8, 8, 0));
		wr(8'h00, 2);
		ptsq_partner_inst.pulse(10);
		pass(8, model_bits(8, 8, 0));
		wr(8'h0c, 0);
		rd(8'h0c);
		chk(rd_v, 1);
		wr(8'h0c, 2);
		wr(8'h00, 8'h89);
		cmd(2);
		pass(3, model_bits(3, 3, 1));
		wr(8'h00, 8'h15);
		pass(8, model_bits(8, 8, 0));
		chk(cyc < 60, 1);
		cmd(1);
		chk(en, 0);
		while (busy === 1'b1)
			@(posedge clk_in);
		wr(8'h00, 0);
		nstb = 0;
		got = 0;
		cmd(1);
		repeat (120) @(posedge clk_in);
		chk(got, model_bits(32, 8, 0));
		cmd(12'h304);
		wr(8'h08, 5);
		wr(8'h00, 8'h59);
		cmd(12'h308);
		chk(en, 0);
		rd(8'h08);
		chk(rd_v, 8);
		rd(8'h00);
		chk(rd_v, 0);
		cmd(1);
		cmd(16);
		chk(en, 0);
		rd(8'h08);
		chk(rd_v, 16);
		report_and_stop;
	end
endmodule // tb_top
